// *** include/rpio_pkg.sv ***
// Package for the rear-panel control I/O block: constants, timing and carrier types
// How it works
// - Test-set bus has thirteen shared lines and three strobes/direction.
// - Up to sixteen daisy-chained test sets share the bus at once.
// - All four test-set select outputs are held at logic zero.
// - Shared lines carry address then latched data, and are bidirectional.
// - Address phase marked by active-low strobe of at least one microsecond.
// - Data phase marked by active-low strobe of at least one microsecond.
// - Direction line high for read, low for write.
// - No sweep starts while the holdoff input is low.
// - Abort input low for ten microseconds aborts the running sweep.
// - Two latched 8-bit output ports and two latched 4-bit bidirectional ports.
// - Trigger low pulse of one microsecond latches the two general outputs.
// - Each bidirectional port has a status output: low input, high output.
// - After handler data update, active-low write strobe of one microsecond.
// - Latched pass/fail output with configurable active polarity.
// - Pass/fail update gives active-low pass/fail strobe of one microsecond.
// - Sweep completion pulses sweep-done low for at least ten microseconds.
// - Handler configuration changes only through the remote command port.
// - Low power-control input is reported as a power-button press.
package rpio_pkg;
    localparam int unsigned RPIO_CLK_HZ = 200_000_000;
    localparam int unsigned RPIO_AD_W = 13;
    localparam int unsigned RPIO_SEL_W = 4;
    localparam int unsigned RPIO_MAX_UNITS = 16;
    // Times in nanoseconds as printed
    localparam int unsigned RPIO_STROBE_MIN_NS = 1_000;
    localparam int unsigned RPIO_LONG_MIN_NS = 10_000;
    localparam int unsigned RPIO_SETUP_NS = 100;
    // Least times round up to whole cycles
    localparam int unsigned RPIO_STROBE_CYC =
        (RPIO_STROBE_MIN_NS * (RPIO_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned RPIO_LONG_CYC =
        (RPIO_LONG_MIN_NS * (RPIO_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned RPIO_SETUP_CYC =
        (RPIO_SETUP_NS * (RPIO_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned RPIO_CNT_W = 12;
    localparam logic [RPIO_SEL_W-1:0] RPIO_SEL_VALUE = 4'h0;

    // Test-set bus request from the CPU
    typedef struct packed {
        logic valid;
        logic read;
        logic [RPIO_AD_W-1:0] addr;
        logic [RPIO_AD_W-1:0] wdata;
    } rpio_tsreq_t;

    // Handler update request from the CPU
    typedef struct packed {
        logic valid;
        logic [7:0] port_a;
        logic [7:0] port_b;
        logic [3:0] port_c;
        logic [3:0] port_d;
        logic c_out;
        logic d_out;
        logic [1:0] general;
    } rpio_hreq_t;

    // Bus machine states
    typedef enum logic [2:0] {
        RPIO_TS_IDLE = 3'b000,
        RPIO_TS_ASET = 3'b001,
        RPIO_TS_ASTB = 3'b010,
        RPIO_TS_DSET = 3'b011,
        RPIO_TS_DSTB = 3'b100
    } rpio_ts_state_t;

    // Handler strobe states
    typedef enum logic [1:0] {
        RPIO_HS_IDLE = 2'b00,
        RPIO_HS_SET = 2'b01,
        RPIO_HS_STB = 2'b10
    } rpio_hs_state_t;
endpackage

// *** src/rpio_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module rpio_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Pin and clean level
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } rpio_sync_st_t;
    rpio_sync_st_t st_q, st_d;

    // Level changes only when stages two and three agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.lvl[i] = st_q.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_q <= {INIT, INIT, INIT, INIT};
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.lvl;
endmodule
`default_nettype wire

// *** src/rpio_top.sv ***
// Rear-panel control I/O: test-set bus master and handler port
`timescale 1ns/1ps
`default_nettype none
module rpio_top
    import rpio_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // CPU side: test-set bus requests
    input wire rpio_tsreq_t ts_req_i,
    output logic ts_busy_o,
    output logic ts_done_o,
    output logic [RPIO_AD_W-1:0] ts_rdata_o,
    // CPU side: handler requests and configuration
    input wire rpio_hreq_t h_req_i,
    input wire logic remote_cfg_i,
    input wire logic pf_valid_i,
    input wire logic pf_pass_i,
    input wire logic pf_pol_i,
    output logic h_busy_o,
    output logic pf_busy_o,
    // CPU side: sweep control
    input wire logic sweep_start_i,
    input wire logic sweep_end_i,
    output logic sweep_go_o,
    output logic sweep_abort_o,
    output logic power_press_o,
    // Test-set bus pins
    output logic [RPIO_SEL_W-1:0] unit_select_o,
    input wire logic [RPIO_AD_W-1:0] shared_addr_data_lines_i,
    output logic [RPIO_AD_W-1:0] shared_addr_data_lines_o,
    output logic shared_addr_data_lines_oe_n_o,
    output logic addr_phase_strobe_n_o,
    output logic data_phase_strobe_n_o,
    output logic direction_read_high_o,
    input wire logic holdoff_n_i,
    input wire logic abort_n_i,
    // Handler pins
    input wire logic latch_trigger_n_i,
    output logic [1:0] general_latched_outputs_o,
    output logic [7:0] wide_output_first_o,
    output logic [7:0] wide_output_second_o,
    input wire logic [3:0] port_c_i,
    output logic [3:0] port_c_o,
    output logic port_c_oe_n_o,
    input wire logic [3:0] port_d_i,
    output logic [3:0] port_d_o,
    output logic port_d_oe_n_o,
    output logic port_c_status_o,
    output logic port_d_status_o,
    output logic data_write_strobe_n_o,
    output logic pass_fail_o,
    output logic pf_write_strobe_n_o,
    output logic sweep_done_n_o,
    // Power pin and read-back of bidirectional ports
    input wire logic power_n_i,
    output logic [3:0] port_c_in_o,
    output logic [3:0] port_d_in_o
);
    // All module state
    typedef struct packed {
        rpio_ts_state_t ts;
        logic [RPIO_CNT_W-1:0] ts_cnt;
        logic ts_read;
        logic [RPIO_AD_W-1:0] ad_out;
        logic ad_oe_n;
        logic las_n;
        logic lds_n;
        logic direction_read_high;
        logic ts_done;
        logic [RPIO_AD_W-1:0] rdata;
        rpio_hs_state_t hs;
        logic [RPIO_CNT_W-1:0] hs_cnt;
        logic [7:0] pa;
        logic [7:0] pb;
        logic [3:0] pc;
        logic [3:0] pd;
        logic c_out;
        logic d_out;
        logic [1:0] gen_pend;
        logic [1:0] gen_out;
        logic dws_n;
        rpio_hs_state_t ps;
        logic [RPIO_CNT_W-1:0] ps_cnt;
        logic pf_lvl;
        logic pfs_n;
        logic [RPIO_CNT_W-1:0] trig_cnt;
        logic trig_armed;
        logic [RPIO_CNT_W-1:0] abort_cnt;
        logic abort_p;
        logic sweeping;
        logic go;
        logic [RPIO_CNT_W-1:0] done_cnt;
        logic done_n;
        logic pwr;
        logic [3:0] cin;
        logic [3:0] din;
        logic [RPIO_CNT_W-1:0] done_low;
    } rpio_st_t;
    rpio_st_t st_q, st_d;

    logic hold_n, abort_n, trig_n, pwr_n;
    logic [3:0] c_in, d_in;

    // Pins from outside the clock domain are filtered
    rpio_sync #(.W(12), .INIT(12'hFFF)) u_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .pin_i({holdoff_n_i, abort_n_i, latch_trigger_n_i, power_n_i, port_c_i, port_d_i}),
        .level_o({hold_n, abort_n, trig_n, pwr_n, c_in, d_in})
    );

    // Checks a strobe timer; true in the last cycle of the programmed width
    function automatic logic cnt_done(input logic [RPIO_CNT_W-1:0] c, input int unsigned n);
        cnt_done = (c >= RPIO_CNT_W'(n - 1));
    endfunction

    // Next-state logic for every part of the block
    always_comb begin
        st_d = st_q;
        st_d.ts_done = 1'b0;
        st_d.abort_p = 1'b0;
        st_d.go = 1'b0;
        st_d.cin = c_in;
        st_d.din = d_in;

        unique case (st_q.ts)
            RPIO_TS_IDLE: begin
                if (ts_req_i.valid) begin
                    st_d.ad_out = ts_req_i.addr;
                    st_d.ad_oe_n = 1'b0;
                    st_d.ts_read = ts_req_i.read;
                    st_d.direction_read_high = ts_req_i.read;
                    st_d.ts_cnt = '0;
                    st_d.ts = RPIO_TS_ASET;
                    if (!ts_req_i.read) begin
                        st_d.rdata = ts_req_i.wdata;
                    end
                end
            end
            RPIO_TS_ASET: begin
                st_d.ts_cnt = st_q.ts_cnt + 1'b1;
                if (cnt_done(st_q.ts_cnt, RPIO_SETUP_CYC)) begin
                    st_d.ts_cnt = '0;
                    st_d.las_n = 1'b0;
                    st_d.ts = RPIO_TS_ASTB;
                end
            end
            RPIO_TS_ASTB: begin
                st_d.ts_cnt = st_q.ts_cnt + 1'b1;
                if (cnt_done(st_q.ts_cnt, RPIO_STROBE_CYC)) begin
                    st_d.ts_cnt = '0;
                    st_d.las_n = 1'b1;
                    st_d.ad_out = st_q.rdata;
                    st_d.ad_oe_n = st_q.ts_read;
                    st_d.ts = RPIO_TS_DSET;
                end
            end
            RPIO_TS_DSET: begin
                st_d.ts_cnt = st_q.ts_cnt + 1'b1;
                if (cnt_done(st_q.ts_cnt, RPIO_SETUP_CYC)) begin
                    st_d.ts_cnt = '0;
                    st_d.lds_n = 1'b0;
                    st_d.ts = RPIO_TS_DSTB;
                end
            end
            RPIO_TS_DSTB: begin
                st_d.ts_cnt = st_q.ts_cnt + 1'b1;
                if (cnt_done(st_q.ts_cnt, RPIO_STROBE_CYC)) begin
                    st_d.lds_n = 1'b1;
                    st_d.ad_oe_n = 1'b1;
                    st_d.ts_done = 1'b1;
                    if (st_q.ts_read) begin
                        st_d.rdata = shared_addr_data_lines_i;
                    end
                    st_d.ts = RPIO_TS_IDLE;
                end
            end
            default: st_d.ts = RPIO_TS_IDLE;
        endcase

        // updates accepted only from remote commands
        unique case (st_q.hs)
            RPIO_HS_IDLE: begin
                if (h_req_i.valid && remote_cfg_i) begin
                    st_d.pa = h_req_i.port_a;
                    st_d.pb = h_req_i.port_b;
                    st_d.pc = h_req_i.port_c;
                    st_d.pd = h_req_i.port_d;
                    st_d.c_out = h_req_i.c_out;
                    st_d.d_out = h_req_i.d_out;
                    st_d.gen_pend = h_req_i.general;
                    st_d.hs_cnt = '0;
                    st_d.hs = RPIO_HS_SET;
                end
            end
            RPIO_HS_SET: begin
                st_d.hs_cnt = st_q.hs_cnt + 1'b1;
                if (cnt_done(st_q.hs_cnt, RPIO_SETUP_CYC)) begin
                    st_d.hs_cnt = '0;
                    st_d.dws_n = 1'b0;
                    st_d.hs = RPIO_HS_STB;
                end
            end
            RPIO_HS_STB: begin
                st_d.hs_cnt = st_q.hs_cnt + 1'b1;
                if (cnt_done(st_q.hs_cnt, RPIO_STROBE_CYC)) begin
                    st_d.dws_n = 1'b1;
                    st_d.hs = RPIO_HS_IDLE;
                end
            end
            default: st_d.hs = RPIO_HS_IDLE;
        endcase

        unique case (st_q.ps)
            RPIO_HS_IDLE: begin
                if (pf_valid_i) begin
                    st_d.pf_lvl = pf_pass_i ^ pf_pol_i;
                    st_d.ps_cnt = '0;
                    st_d.ps = RPIO_HS_SET;
                end
            end
            RPIO_HS_SET: begin
                st_d.ps_cnt = st_q.ps_cnt + 1'b1;
                if (cnt_done(st_q.ps_cnt, RPIO_SETUP_CYC)) begin
                    st_d.ps_cnt = '0;
                    st_d.pfs_n = 1'b0;
                    st_d.ps = RPIO_HS_STB;
                end
            end
            RPIO_HS_STB: begin
                st_d.ps_cnt = st_q.ps_cnt + 1'b1;
                if (cnt_done(st_q.ps_cnt, RPIO_STROBE_CYC)) begin
                    st_d.pfs_n = 1'b1;
                    st_d.ps = RPIO_HS_IDLE;
                end
            end
            default: st_d.ps = RPIO_HS_IDLE;
        endcase

        if (!trig_n) begin
            if (!cnt_done(st_q.trig_cnt, RPIO_STROBE_CYC)) begin
                st_d.trig_cnt = st_q.trig_cnt + 1'b1;
            end else begin
                st_d.trig_armed = 1'b1;
            end
        end else begin
            st_d.trig_cnt = '0;
            st_d.trig_armed = 1'b0;
            if (st_q.trig_armed) begin
                st_d.gen_out = st_q.gen_pend;
            end
        end

        if (!abort_n) begin
            if (!cnt_done(st_q.abort_cnt, RPIO_LONG_CYC)) begin
                st_d.abort_cnt = st_q.abort_cnt + 1'b1;
            end else if (st_q.sweeping) begin
                st_d.abort_p = 1'b1;
                st_d.sweeping = 1'b0;
            end
        end else begin
            st_d.abort_cnt = '0;
        end

        if (sweep_start_i && hold_n && !st_q.sweeping) begin
            st_d.sweeping = 1'b1;
            st_d.go = 1'b1;
        end

        if (st_q.done_cnt != '0) begin
            st_d.done_cnt = st_q.done_cnt - 1'b1;
            if (st_q.done_cnt == RPIO_CNT_W'(1)) begin
                st_d.done_n = 1'b1;
            end
        end
        if (sweep_end_i && st_q.sweeping && !st_d.abort_p) begin
            st_d.sweeping = 1'b0;
            st_d.done_n = 1'b0;
            st_d.done_cnt = RPIO_CNT_W'(RPIO_LONG_CYC);
        end
        // Low-time count for the width check; saturates so a re-armed pulse cannot wrap
        if (st_q.done_n) begin
            st_d.done_low = '0;
        end else if (st_q.done_low != '1) begin
            st_d.done_low = st_q.done_low + 1'b1;
        end

        st_d.pwr = !pwr_n;
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_q <= '0;
            st_q.ts <= RPIO_TS_IDLE;
            st_q.hs <= RPIO_HS_IDLE;
            st_q.ps <= RPIO_HS_IDLE;
            st_q.ad_oe_n <= 1'b1;
            st_q.las_n <= 1'b1;
            st_q.lds_n <= 1'b1;
            st_q.direction_read_high <= 1'b1;
            st_q.dws_n <= 1'b1;
            st_q.pfs_n <= 1'b1;
            st_q.done_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // select bits low, every chained unit answers
    assign unit_select_o = RPIO_SEL_VALUE;
    assign shared_addr_data_lines_o = st_q.ad_out;
    assign shared_addr_data_lines_oe_n_o = st_q.ad_oe_n;
    assign addr_phase_strobe_n_o = st_q.las_n;
    assign data_phase_strobe_n_o = st_q.lds_n;
    assign direction_read_high_o = st_q.direction_read_high;
    assign ts_busy_o = (st_q.ts != RPIO_TS_IDLE);
    assign ts_done_o = st_q.ts_done;
    assign ts_rdata_o = st_q.rdata;
    assign wide_output_first_o = st_q.pa;
    assign wide_output_second_o = st_q.pb;
    assign port_c_o = st_q.pc;
    assign port_d_o = st_q.pd;
    assign port_c_oe_n_o = !st_q.c_out;
    assign port_d_oe_n_o = !st_q.d_out;
    assign port_c_status_o = st_q.c_out;
    assign port_d_status_o = st_q.d_out;
    assign port_c_in_o = st_q.cin;
    assign port_d_in_o = st_q.din;
    assign general_latched_outputs_o = st_q.gen_out;
    assign data_write_strobe_n_o = st_q.dws_n;
    assign h_busy_o = (st_q.hs != RPIO_HS_IDLE);
    assign pass_fail_o = st_q.pf_lvl;
    assign pf_write_strobe_n_o = st_q.pfs_n;
    assign pf_busy_o = (st_q.ps != RPIO_HS_IDLE);
    assign sweep_done_n_o = st_q.done_n;
    assign sweep_go_o = st_q.go;
    assign sweep_abort_o = st_q.abort_p;
    assign power_press_o = st_q.pwr;

    // Strobe widths: address and write strobes checked to 199-201 low cycles, sweep-done strobe to the documented minimum, data strobe to 8 cycles only
    AST_LAS_WIDTH: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $fell(addr_phase_strobe_n_o) |-> !addr_phase_strobe_n_o [*8])
        else $error("address strobe too short");
    AST_LDS_WIDTH: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $fell(data_phase_strobe_n_o) |-> !data_phase_strobe_n_o [*8])
        else $error("data strobe too short");
    AST_LAS_END: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $fell(addr_phase_strobe_n_o) |-> ##[199:201] addr_phase_strobe_n_o)
        else $error("address strobe wrong length");
    AST_ADDR_STABLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !addr_phase_strobe_n_o |-> $stable(shared_addr_data_lines_o) && !shared_addr_data_lines_oe_n_o)
        else $error("address moved under strobe");
    AST_RLW_STABLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (!data_phase_strobe_n_o || !addr_phase_strobe_n_o) |-> $stable(direction_read_high_o))
        else $error("direction changed mid cycle");
    AST_READ_RELEASE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (!data_phase_strobe_n_o && direction_read_high_o) |-> shared_addr_data_lines_oe_n_o)
        else $error("lines driven during read");
    AST_SEL_ZERO: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        unit_select_o == 4'h0)
        else $error("select bits not zero");
    AST_DWS_DATA: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !data_write_strobe_n_o |-> $stable(wide_output_first_o) && $stable(port_c_o))
        else $error("handler data moved under strobe");
    AST_DWS_WIDTH: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $fell(data_write_strobe_n_o) |-> ##[199:201] data_write_strobe_n_o)
        else $error("write strobe wrong length");
    AST_PFS_DATA: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !pf_write_strobe_n_o |-> $stable(pass_fail_o) ##1 1'b1)
        else $error("pass fail moved under strobe");
    AST_DONE_WIDTH: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(sweep_done_n_o) |-> st_q.done_low >= RPIO_CNT_W'(RPIO_LONG_CYC))
        else $error("sweep done pulse too short");
    AST_STATUS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        port_c_status_o == !port_c_oe_n_o && port_d_status_o == !port_d_oe_n_o)
        else $error("status disagrees with direction");
endmodule
`default_nettype wire

// *** testbench/rpio_tset_model.sv ***
// Behavioural test set on the far side of the test-set bus
`timescale 1ns/1ps
`default_nettype none
module rpio_tset_model
    import rpio_pkg::*;
(
    // Clock and bus pins
    input wire logic sys_clk_i,
    input wire logic [RPIO_AD_W-1:0] ad_o_i,
    input wire logic ad_oe_n_i,
    input wire logic las_n_i,
    input wire logic lds_n_i,
    input wire logic rlw_i,
    // Resolved lines and captured values
    output logic [RPIO_AD_W-1:0] ad_line_o,
    output logic [RPIO_AD_W-1:0] addr_o,
    output logic [RPIO_AD_W-1:0] data_o,
    output logic rlw_o
);
    logic [RPIO_AD_W-1:0] last_q = '0;
    logic [3:0] hold_q = 4'h0;
    logic drive;
    // read answer is the inverted address, held 8 cycles past the strobe
    assign drive = rlw_i && ad_oe_n_i && (hold_q != 4'h0);
    // Released lines show the inverse of history, so a stale sample cannot pass
    assign ad_line_o = !ad_oe_n_i ? ad_o_i : drive ? ~addr_o : ~last_q;
    // one unit captures address and direction, then data
    always_ff @(posedge sys_clk_i) begin
        last_q <= ad_line_o;
        hold_q <= !lds_n_i ? 4'h8 : (hold_q != 4'h0) ? hold_q - 4'h1 : 4'h0;
        if (!las_n_i) begin
            addr_o <= ad_line_o;
            rlw_o <= rlw_i;
        end
        if (!lds_n_i) data_o <= ad_line_o;
    end
endmodule
`default_nettype wire

// *** testbench/tb_rpio_top.sv ***
// Self-checking bench for the rear-panel control I/O block
`timescale 1ns/1ps
`default_nettype none
module tb_rpio_top import rpio_pkg::*;;
    // Stimulus, all given a value at time zero
    logic sys_clk_i = 1'b0, reset_i = 1'b1;
    rpio_tsreq_t ts_req = '0;
    rpio_hreq_t h_req = '0;
    logic rem = 0, pf_valid = 0, pf_pass = 0, pf_pol = 0, s_start = 0, s_end = 0;
    logic holdoff_n = 1, abort_n = 1, trig_n = 1, power_n = 1;
    logic [3:0] ext_c = 4'h5, ext_d = 4'h9, pc_pin, pd_pin, pc_o, pd_o, pc_in, pd_in, unit_sel;
    // Observed outputs
    logic ts_done, s_go, s_abort, press, ad_oe_n, las_n, lds_n, direction_read_high, pc_oe_n, pd_oe_n;
    logic pc_st, pd_st, dws_n, pf_o, pfws_n, done_n, t_rlw, ts_busy, h_busy, pf_busy;
    logic [1:0] gen;
    logic [7:0] wa, wb;
    logic [12:0] ts_rdata, ad_o, ad_line, t_addr, t_data;
    logic [4:0] strb;
    int err_total = 0, checked = 0, cyc = 0, go_seen = 0, ab_seen = 0;

    always #2.5 sys_clk_i = ~sys_clk_i;
    assign strb = {done_n, pfws_n, dws_n, lds_n, las_n};
    // Bidirectional handler pins resolve from the enables
    assign pc_pin = pc_oe_n ? ext_c : pc_o;
    assign pd_pin = pd_oe_n ? ext_d : pd_o;

    rpio_top dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .ts_req_i(ts_req),
        .ts_busy_o(ts_busy), .ts_done_o(ts_done), .ts_rdata_o(ts_rdata), .h_req_i(h_req),
        .remote_cfg_i(rem), .pf_valid_i(pf_valid), .pf_pass_i(pf_pass), .pf_pol_i(pf_pol),
        .h_busy_o(h_busy), .pf_busy_o(pf_busy), .sweep_start_i(s_start), .sweep_end_i(s_end),
        .sweep_go_o(s_go), .sweep_abort_o(s_abort), .power_press_o(press),
        .unit_select_o(unit_sel), .shared_addr_data_lines_i(ad_line),
        .shared_addr_data_lines_o(ad_o), .shared_addr_data_lines_oe_n_o(ad_oe_n),
        .addr_phase_strobe_n_o(las_n), .data_phase_strobe_n_o(lds_n),
        .direction_read_high_o(direction_read_high), .holdoff_n_i(holdoff_n), .abort_n_i(abort_n),
        .latch_trigger_n_i(trig_n), .general_latched_outputs_o(gen),
        .wide_output_first_o(wa), .wide_output_second_o(wb), .port_c_i(pc_pin),
        .port_c_o(pc_o), .port_c_oe_n_o(pc_oe_n), .port_d_i(pd_pin), .port_d_o(pd_o),
        .port_d_oe_n_o(pd_oe_n), .port_c_status_o(pc_st), .port_d_status_o(pd_st),
        .data_write_strobe_n_o(dws_n), .pass_fail_o(pf_o), .pf_write_strobe_n_o(pfws_n),
        .sweep_done_n_o(done_n), .power_n_i(power_n), .port_c_in_o(pc_in),
        .port_d_in_o(pd_in));

    rpio_tset_model tset (.sys_clk_i(sys_clk_i), .ad_o_i(ad_o), .ad_oe_n_i(ad_oe_n),
        .las_n_i(las_n), .lds_n_i(lds_n), .rlw_i(direction_read_high), .ad_line_o(ad_line),
        .addr_o(t_addr), .data_o(t_data), .rlw_o(t_rlw));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // Wait for a strobe to fall, then count its low cycles on settled edges
    task automatic plen(input int idx, output int n);
        int w;
        w = 0;
        n = 0;
        while (strb[idx] !== 1'b0 && w < 1000) begin
            @(negedge sys_clk_i);
            w++;
        end
        while (strb[idx] === 1'b0 && n < 3000) begin
            @(negedge sys_clk_i);
            n++;
        end
    endtask

    task automatic ts_xfer(input logic rd, input logic [12:0] a, input logic [12:0] d);
        int n;
        @(negedge sys_clk_i);
        ts_req = '{valid: 1'b1, read: rd, addr: a, wdata: d};
        @(negedge sys_clk_i);
        ts_req.valid = 1'b0;
        chk(ts_busy, 1);
        plen(0, n);
        chk(n >= RPIO_STROBE_CYC, 1);
        plen(1, n);
        chk(n >= RPIO_STROBE_CYC, 1);
        chk(ts_done, 1);
        chk(t_rlw, rd);
        chk(t_addr, a);
        chk(t_data, rd ? 13'(~a) : d);
    endtask

    task automatic h_upd(input logic r, input logic [7:0] a, input logic [7:0] b);
        int n;
        @(negedge sys_clk_i);
        rem = r;
        h_req = '{1'b1, a, b, 4'hC, 4'h3, 1'b1, 1'b0, 2'h2};
        @(negedge sys_clk_i);
        h_req.valid = 1'b0;
        chk(h_busy, r);
        plen(2, n);
        chk(n >= RPIO_STROBE_CYC, r);
    endtask

    task automatic pf_upd(input logic pol);
        int n;
        @(negedge sys_clk_i);
        pf_valid = 1'b1;
        pf_pass = 1'b1;
        pf_pol = pol;
        @(negedge sys_clk_i);
        pf_valid = 1'b0;
        chk(pf_busy, 1);
        plen(3, n);
        chk(n >= RPIO_STROBE_CYC, 1);
        chk(pf_o, !pol);
    endtask

    // Sweep start (k=0) or end (k=1) as a one-cycle pulse; an end returns at once
    // so the done pulse can be timed from its first low cycle
    task automatic pulse(input int k);
        @(negedge sys_clk_i);
        {s_end, s_start} = (k == 0) ? 2'b01 : 2'b10;
        @(negedge sys_clk_i);
        {s_end, s_start} = 2'b00;
        if (k == 0) repeat (10) @(negedge sys_clk_i);
    endtask

    task give_verdict();
        if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Event counters and the hang limit, well above the run's length
    always @(negedge sys_clk_i) begin
        cyc++;
        if (s_go === 1'b1) go_seen++;
        if (s_abort === 1'b1) ab_seen++;
        if (cyc == 40000) begin
            err_total++;
            give_verdict();
        end
    end

    initial begin
        int n;
        repeat (10) @(negedge sys_clk_i);
        reset_i = 1'b0;
        chk(unit_sel, 4'h0);
        ts_xfer(1'b0, 13'h1ABC, 13'h0F0F);
        ts_xfer(1'b1, 13'h0123, 13'h0000);
        chk(ts_rdata, 13'h1EDC);
        h_upd(1'b1, 8'hA5, 8'h3C);
        h_upd(1'b0, 8'h11, 8'h22);
        chk({wa, wb, pc_o, pd_st, pc_st, pc_oe_n, pd_oe_n}, 24'hA53CC5);
        chk({pc_in, pd_in, pd_o}, 12'hC93);
        pf_upd(1'b0);
        pf_upd(1'b1);
        trig_n = 1'b0;
        repeat (210) @(negedge sys_clk_i);
        trig_n = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        chk(gen, 2'h2);
        power_n = 1'b0;
        repeat (10) @(negedge sys_clk_i);
        chk(press, 1'b1);
        power_n = 1'b1;
        holdoff_n = 1'b0;
        repeat (10) @(negedge sys_clk_i);
        pulse(0);
        chk(go_seen, 0);
        holdoff_n = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        pulse(0);
        chk(go_seen, 1);
        pulse(1);
        plen(4, n);
        chk(n >= RPIO_LONG_CYC, 1);
        pulse(0);
        abort_n = 1'b0;
        repeat (2100) @(negedge sys_clk_i);
        abort_n = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        chk(ab_seen, 1);
        give_verdict();
    end
endmodule
`default_nettype wire
